// File: logic/display_host_frontend.sv
// Host interface front end: strap decode, parallel and serial byte intake
// Assumes all pins are asynchronous to mclk and far slower than it
// What this block does
// - The three strap inputs select I2C, 3-wire, 4-wire, 68-style or 80-style host protocol.
// - While the init input is low all interface state returns to its defaults.
// - Host activity is taken only while chip select is low and ignored while it is high.
// - In parallel modes a written byte goes to display data when the selector is high, else command.
// - A received byte is display data, else command, when the selector is high in 4-wire mode or the leading bit is high in 3-wire mode.
// - In I2C mode the selector level is the lowest slave address bit the host must match.
// - In 68-style mode a cycle begins when the enable strobe rises with chip select low.
// - In 80-style mode a read starts when the read strobe goes low with chip select low.
// - In 80-style mode the direction pin is a write strobe; a write byte is taken when it returns high.
// - In parallel modes the eight data pins are driven on reads and sampled on writes.
// - In serial modes data line one is serial data and data line zero is the serial clock.
// - In I2C mode line two drives SDA, line one reads SDA and line zero is SCL.
`timescale 1ns/1ps
`default_nettype none
module display_host_frontend #(
  parameter logic [5:0] I2C_ADDR_HIGH = 6'h15
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic proto_sel_bit0,
  input wire logic proto_sel_bit1,
  input wire logic proto_sel_bit2,
  input wire logic chip_init_n,
  input wire logic chip_sel_n,
  input wire logic dc_sel,
  input wire logic strobe_e_rd,
  input wire logic strobe_rw_wr,
  input wire logic [hostif_pkg::DATA_W-1:0] pin_data_in,
  output logic [hostif_pkg::DATA_W-1:0] pin_data_out,
  output logic [hostif_pkg::DATA_W-1:0] pin_data_oe_n,
  input wire logic [hostif_pkg::DATA_W-1:0] rd_data,
  output logic rd_req,
  output logic byte_valid,
  output logic [hostif_pkg::DATA_W-1:0] byte_data,
  output logic byte_is_data,
  output var hostif_pkg::mode_type proto_mode,
  output logic init_active
);
  import hostif_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] syn;
  logic [SYNC_W-1:0] prev;
  logic [SYNC_W-1:0] next_prev;
  logic [DATA_W-1:0] bus_in;
  logic cs_on;
  logic dc;
  logic e_rd;
  logic rw_wr;
  logic sclk;
  logic serial_data_in;
  logic e_rise;
  logic e_fall;
  logic wr_rise;
  logic scl_rise;
  logic scl_fall;
  logic sda_fall;
  logic sda_rise;

  assign pin_raw = {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0, chip_init_n,
                    strobe_rw_wr, strobe_e_rd, dc_sel, chip_sel_n, pin_data_in};

  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din(pin_raw),
    .dout(syn)
  );

  assign bus_in = syn[IDX_DATA +: DATA_W];
  assign cs_on = ~syn[IDX_CS_N];
  assign dc = syn[IDX_DC];
  assign e_rd = syn[IDX_E_RD];
  assign rw_wr = syn[IDX_RW_WR];
  // clock on line zero, data on line one
  assign sclk = syn[PIN_SCLK];
  assign serial_data_in = syn[PIN_SERIAL_DATA_IN];
  assign e_rise = e_rd & ~prev[IDX_E_RD];
  assign e_fall = ~e_rd & prev[IDX_E_RD];
  assign wr_rise = rw_wr & ~prev[IDX_RW_WR];
  assign scl_rise = sclk & ~prev[PIN_SCLK];
  assign scl_fall = ~sclk & prev[PIN_SCLK];
  // start and stop seen on the SDA input line
  assign sda_fall = sclk & prev[PIN_SCLK] & ~serial_data_in & prev[PIN_SERIAL_DATA_IN];
  assign sda_rise = sclk & prev[PIN_SCLK] & serial_data_in & ~prev[PIN_SERIAL_DATA_IN];

  // ----------------------------------------------------------------
  // Reset, release guard and strap capture
  // ----------------------------------------------------------------
  logic rst_raw;
  logic rst_int;
  logic armed;
  logic next_armed;
  mode_type mode;
  mode_type next_mode;

  // init pin low holds the block in reset
  assign rst_raw = srst | ~syn[IDX_INIT_N];
  // Extra cycle lets the edge history fill with real pin levels
  assign rst_int = rst_raw | ~armed;
  assign init_active = rst_int;
  assign proto_mode = mode;

  always_comb begin
    next_prev = syn;
    next_armed = ~rst_raw;
    // straps taken while in reset, frozen afterwards
    next_mode = rst_int ? decode_strap(syn[IDX_STRAP +: 3]) : mode;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev <= '0;
      armed <= 1'b0;
    end else begin
      prev <= next_prev;
      armed <= next_armed;
    end
    mode <= next_mode;
  end

  // ----------------------------------------------------------------
  // Serial bit collector
  // ----------------------------------------------------------------
  logic col_clear;
  logic col_shift;
  logic [FRAME_W-1:0] col_value;
  logic [CNT_W-1:0] col_count;
  logic [CNT_W-1:0] frame_last;
  logic [DATA_W-1:0] serial_byte;

  bit_collector #(.WIDTH(FRAME_W)) u_collect (
    .mclk(mclk),
    .srst(rst_int),
    .clear(col_clear),
    .shift(col_shift),
    .bit_in(serial_data_in),
    .value(col_value),
    .count(col_count)
  );

  assign serial_byte = {col_value[DATA_W-2:0], serial_data_in};
  assign frame_last = (mode == mode_spi3) ? SPI3_LAST : SPI4_LAST;

  // ----------------------------------------------------------------
  // Transfer logic for all protocols
  // ----------------------------------------------------------------
  i2c_state_type state;
  i2c_state_type next_state;
  logic ack_drive;
  logic next_ack;
  logic i2c_co;
  logic next_co;
  logic i2c_dc;
  logic next_i2c_dc;
  logic addr_match;
  logic next_byte_valid;
  logic [DATA_W-1:0] next_byte_data;
  logic next_byte_is_data;
  logic next_rd_req;
  logic [DATA_W-1:0] next_out;
  logic [DATA_W-1:0] next_oe_n;

  // selector pin supplies the address LSB, writes only
  assign addr_match = serial_byte[DATA_W-1:1] == {I2C_ADDR_HIGH, dc} && !serial_byte[0];

  always_comb begin
    next_byte_valid = 1'b0;
    next_byte_data = byte_data;
    next_byte_is_data = byte_is_data;
    next_rd_req = 1'b0;
    next_out = pin_data_out;
    next_oe_n = OE_ALL_OFF;
    next_state = state;
    next_ack = ack_drive;
    next_co = i2c_co;
    next_i2c_dc = i2c_dc;
    col_clear = 1'b0;
    col_shift = 1'b0;
    if (!cs_on) begin
      // deselected: drop any frame in progress
      col_clear = 1'b1;
      next_state = st_idle;
      next_ack = 1'b0;
    end else begin
      case (mode)
        mode_par68: begin
          // enable rise opens the cycle, direction high reads
          if (e_rise && rw_wr) begin
            next_rd_req = 1'b1;
          end
          // drive the bus for the whole read strobe
          if (e_rd && rw_wr) begin
            next_out = rd_data;
            next_oe_n = OE_ALL_ON;
          end
          // write byte taken as enable falls
          if (e_fall && !rw_wr) begin
            next_byte_valid = 1'b1;
            next_byte_data = bus_in;
            next_byte_is_data = dc;
          end
        end
        mode_par80: begin
          // read strobe low drives the bus
          if (!e_rd) begin
            next_out = rd_data;
            next_oe_n = OE_ALL_ON;
          end
          if (e_fall) begin
            next_rd_req = 1'b1;
          end
          // write byte taken as the write strobe returns high
          if (wr_rise) begin
            next_byte_valid = 1'b1;
            next_byte_data = bus_in;
            next_byte_is_data = dc;
          end
        end
        mode_spi4, mode_spi3: begin
          // sample on clock rise, selector or leading bit sets the path
          if (scl_rise) begin
            col_shift = 1'b1;
            if (col_count == frame_last) begin
              col_clear = 1'b1;
              next_byte_valid = 1'b1;
              next_byte_data = serial_byte;
              next_byte_is_data = (mode == mode_spi3) ? col_value[SPI3_DC_POS] : dc;
            end
          end
        end
        mode_i2c: begin
          if (sda_fall) begin
            col_clear = 1'b1;
            next_state = st_addr;
            next_ack = 1'b0;
          end else if (sda_rise) begin
            col_clear = 1'b1;
            next_state = st_idle;
            next_ack = 1'b0;
          end else begin
            case (state)
              st_addr, st_ctrl, st_data: begin
                if (scl_rise) begin
                  col_shift = 1'b1;
                  if (col_count == I2C_LAST) begin
                    col_clear = 1'b1;
                    if (state == st_addr) begin
                      // foreign address or read request is not answered
                      next_state = addr_match ? st_addr_ack : st_idle;
                    end else if (state == st_ctrl) begin
                      next_co = serial_byte[CTRL_CO_POS];
                      next_i2c_dc = serial_byte[CTRL_DC_POS];
                      next_state = st_ctrl_ack;
                    end else begin
                      next_byte_valid = 1'b1;
                      next_byte_data = serial_byte;
                      next_byte_is_data = i2c_dc;
                      next_state = st_data_ack;
                    end
                  end
                end
              end
              st_addr_ack, st_ctrl_ack, st_data_ack: begin
                // Pull SDA from the falling clock after bit 8 to the next fall
                if (scl_fall) begin
                  next_ack = ~ack_drive;
                  if (ack_drive) begin
                    if (state == st_addr_ack) begin
                      next_state = st_ctrl;
                    end else if (state == st_ctrl_ack) begin
                      next_state = st_data;
                    end else begin
                      next_state = i2c_co ? st_ctrl : st_data;
                    end
                  end
                end
              end
              default: begin
                next_ack = 1'b0;
              end
            endcase
          end
          // acknowledge goes out on line two only
          next_out[PIN_SDA_OUT] = 1'b0;
          next_oe_n[PIN_SDA_OUT] = ~next_ack;
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    // defaults while init or reset is active
    if (rst_int) begin
      byte_valid <= 1'b0;
      byte_data <= DATA_RESET;
      byte_is_data <= 1'b0;
      rd_req <= 1'b0;
      pin_data_out <= DATA_RESET;
      pin_data_oe_n <= OE_ALL_OFF;
      state <= st_idle;
      ack_drive <= 1'b0;
      i2c_co <= 1'b0;
      i2c_dc <= 1'b0;
    end else begin
      byte_valid <= next_byte_valid;
      byte_data <= next_byte_data;
      byte_is_data <= next_byte_is_data;
      rd_req <= next_rd_req;
      pin_data_out <= next_out;
      pin_data_oe_n <= next_oe_n;
      state <= next_state;
      ack_drive <= next_ack;
      i2c_co <= next_co;
      i2c_dc <= next_i2c_dc;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_strap_frozen: assert property (
    @(posedge mclk) disable iff (srst) !rst_int |=> mode == $past(mode))
    else $error("protocol mode changed outside reset");

  a_init_defaults: assert property (
    @(posedge mclk) rst_int |=> !byte_valid && pin_data_oe_n == OE_ALL_OFF && state == st_idle)
    else $error("outputs not at defaults after init");

  a_cs_ignores: assert property (
    @(posedge mclk) disable iff (rst_int)
    !cs_on |=> !byte_valid && !rd_req && pin_data_oe_n == OE_ALL_OFF)
    else $error("activity while chip select high");

  a_par68_write: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_par68 && cs_on && e_fall && !rw_wr
    |=> byte_valid && byte_data == $past(bus_in) && byte_is_data == $past(dc))
    else $error("68-style write byte wrong");

  a_par68_read: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_par68 && cs_on && e_rise && rw_wr |=> rd_req ##1 !rd_req)
    else $error("68-style read start not a single pulse");

  a_par80_read: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_par80 && cs_on && !e_rd
    |=> pin_data_oe_n == OE_ALL_ON && pin_data_out == $past(rd_data))
    else $error("80-style read does not drive the bus");

  a_par80_write: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_par80 && cs_on && wr_rise |=> byte_valid && byte_data == $past(bus_in))
    else $error("80-style write byte missing");

  a_spi4_byte: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_spi4 && cs_on && scl_rise && col_count == SPI4_LAST
    |=> byte_valid && byte_data == $past(serial_byte) && byte_is_data == $past(dc)
        ##1 col_count == 4'h0)
    else $error("4-wire byte not delivered on the eighth clock");

  a_i2c_addr: assert property (
    @(posedge mclk) disable iff (rst_int)
    mode == mode_i2c && cs_on && state == st_addr && scl_rise && col_count == I2C_LAST
    && !sda_fall && !sda_rise && !addr_match |=> state == st_idle [*2])
    else $error("foreign address was accepted");

  a_i2c_ack_line: assert property (
    @(posedge mclk) disable iff (rst_int)
    pin_data_oe_n[PIN_SDA_OUT] == 1'b0 && mode == mode_i2c
    |-> pin_data_out[PIN_SDA_OUT] == 1'b0 && pin_data_oe_n[DATA_W-1:PIN_SDA_OUT+1] == 5'h1F)
    else $error("acknowledge not on line two alone");

endmodule : display_host_frontend
`default_nettype wire

// File: inc/hostif_pkg.sv
// Shared constants, mode type and strap decoding for the host interface front end
// Assumes pins are sampled on mclk after a two-stage synchroniser
package hostif_pkg;

  // ----------------------------------------------------------------
  // Widths and synchroniser vector layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int FRAME_W = 9;
  localparam int SYNC_W = 16;
  localparam int IDX_DATA = 0;
  localparam int IDX_CS_N = 8;
  localparam int IDX_DC = 9;
  localparam int IDX_E_RD = 10;
  localparam int IDX_RW_WR = 11;
  localparam int IDX_INIT_N = 12;
  localparam int IDX_STRAP = 13;

  // ----------------------------------------------------------------
  // Data pin roles in serial and two-wire modes
  // ----------------------------------------------------------------
  localparam int PIN_SCLK = 0;
  localparam int PIN_SERIAL_DATA_IN = 1;
  localparam int PIN_SDA_OUT = 2;

  // ----------------------------------------------------------------
  // Strap codes, written {bit2, bit1, bit0}
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_I2C = 3'h2;
  localparam logic [2:0] STRAP_SPI3 = 3'h1;
  localparam logic [2:0] STRAP_SPI4 = 3'h0;
  localparam logic [2:0] STRAP_PAR68 = 3'h4;
  localparam logic [2:0] STRAP_PAR80 = 3'h6;

  // ----------------------------------------------------------------
  // Frame counts, field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SPI4_LAST = 4'h7;
  localparam logic [CNT_W-1:0] SPI3_LAST = 4'h8;
  localparam logic [CNT_W-1:0] I2C_LAST = 4'h7;
  localparam int SPI3_DC_POS = 7;
  localparam int CTRL_CO_POS = 7;
  localparam int CTRL_DC_POS = 6;
  localparam logic [DATA_W-1:0] OE_ALL_OFF = 8'hFF;
  localparam logic [DATA_W-1:0] OE_ALL_ON = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    mode_i2c, mode_spi3, mode_spi4, mode_par68, mode_par80, mode_none
  } mode_type;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_ctrl, st_ctrl_ack, st_data, st_data_ack
  } i2c_state_type;

  function automatic mode_type decode_strap(input logic [2:0] code);
    mode_type m;
    m = mode_none;
    case (code)
      STRAP_I2C: m = mode_i2c;
      STRAP_SPI3: m = mode_spi3;
      STRAP_SPI4: m = mode_spi4;
      STRAP_PAR68: m = mode_par68;
      STRAP_PAR80: m = mode_par80;
      default: m = mode_none;
    endcase
    return m;
  endfunction : decode_strap

endpackage : hostif_pkg

// File: logic/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins
// Assumes each bit is an independent level; no word coherence is given
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = hostif_pkg::SYNC_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import hostif_pkg::*;

  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pin_sync: WIDTH must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // One flip-flop pair per pin; stage1 feeds only the second stage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (srst) begin
        stage1[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        stage1[i] <= din[i];
        dout[i] <= stage1[i];
      end
    end
  end

  a_sync_latency: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> dout == $past(din, 2))
    else $error("synchroniser output is not the input two cycles back");

endmodule : pin_sync
`default_nettype wire

// File: logic/bit_collector.sv
// Serial bit collector: shifts bits in MSB first and counts them
// Assumes clear and shift come from logic on mclk; clear wins over shift
`timescale 1ns/1ps
`default_nettype none
module bit_collector #(
  parameter int WIDTH = hostif_pkg::FRAME_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clear,
  input wire logic shift,
  input wire logic bit_in,
  output logic [WIDTH-1:0] value,
  output logic [hostif_pkg::CNT_W-1:0] count
);
  import hostif_pkg::*;

  logic [WIDTH-1:0] next_value;
  logic [CNT_W-1:0] next_count;

  generate
    if (WIDTH < 2 || WIDTH > 15) begin : g_bad
      $error("bit_collector: WIDTH must lie between 2 and 15");
    end
  endgenerate

  always_comb begin
    next_value = value;
    next_count = count;
    if (clear) begin
      next_value = '0;
      next_count = '0;
    end else if (shift) begin
      next_value = {value[WIDTH-2:0], bit_in};
      next_count = count + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      value <= '0;
      count <= '0;
    end else begin
      value <= next_value;
      count <= next_count;
    end
  end

  a_count_steps: assert property (@(posedge mclk) disable iff (srst)
    shift && !clear |=> count == $past(count) + 4'h1 && value[0] == $past(bit_in))
    else $error("collector did not advance on shift");

endmodule : bit_collector
`default_nettype wire

// File: verif/host_bfm.sv
// Host bus master model: chip select, selector, strobes and data pins
// Assumes one bench process calls its tasks, all timed on mclk edges
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
  input wire logic mclk,
  input wire logic two_wire,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] dout,
  output var logic cs_n,
  output var logic dc,
  output var logic e_rd,
  output var logic rw_wr,
  output var logic [7:0] pins
);
  logic [7:0] hd = 8'h00;
  logic hen = 1'b0;
  logic sda_low = 1'b0;
  logic sda;
  initial begin
    cs_n = 1'b1;
    dc = 1'b0;
    e_rd = 1'b0;
    rw_wr = 1'b0;
  end
  assign sda = !sda_low && (oe_n[2] || dout[2]);
  // Released bus shows inverse, unused lines grounded
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins[i] = !oe_n[i] ? dout[i] : (hen ? hd[i] : ~dout[i]);
    end
    if (two_wire) begin
      pins = {5'h00, sda, sda, hd[0]};
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic idle(input logic m80);
    @(posedge mclk);
    e_rd <= m80;
    rw_wr <= m80;
    cs_n <= 1'b1;
    hen <= 1'b0;
  endtask : idle
  task automatic par_write(input logic m80, input logic c, input logic d, input logic [7:0] b);
    @(posedge mclk);
    cs_n <= c;
    dc <= d;
    hd <= b;
    hen <= 1'b1;
    rw_wr <= m80;
    tick(8);
    rw_wr <= 1'b0;
    // Enable high in 68 style, read strobe stays idle high in 80 style
    e_rd <= 1'b1;
    tick(8);
    rw_wr <= m80;
    e_rd <= m80;
    tick(8);
    cs_n <= 1'b1;
    hen <= 1'b0;
    tick(4);
  endtask : par_write
  // Read cycle, bus sampled while strobe active
  task automatic par_read(input logic m80, output logic [7:0] v);
    @(posedge mclk);
    cs_n <= 1'b0;
    hen <= 1'b0;
    rw_wr <= 1'b1;
    e_rd <= m80;
    tick(8);
    e_rd <= !m80;
    tick(10);
    v = pins;
    e_rd <= m80;
    tick(8);
    cs_n <= 1'b1;
  endtask : par_read
  // Clock on line zero, data on line one, 80 ns period
  task automatic spi(input int n, input logic [8:0] v, input logic d);
    @(posedge mclk);
    cs_n <= 1'b0;
    dc <= d;
    hen <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      hd <= {6'h00, v[i], 1'b0};
      tick(8);
      hd[0] <= 1'b1;
      tick(8);
    end
    hd <= 8'h00;
    tick(8);
    cs_n <= 1'b1;
    tick(4);
  endtask : spi
  task automatic i2c_start(input logic a0);
    @(posedge mclk);
    cs_n <= 1'b0;
    dc <= a0;
    hen <= 1'b1;
    hd <= 8'h01;
    sda_low <= 1'b0;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
    hd[0] <= 1'b0;
    tick(4);
  endtask : i2c_start
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      tick(4);
      hd[0] <= 1'b1;
      tick(8);
      hd[0] <= 1'b0;
      tick(4);
    end
    sda_low <= 1'b0;
    tick(4);
    hd[0] <= 1'b1;
    tick(6);
    ack = !pins[1];
    tick(2);
    hd[0] <= 1'b0;
    tick(4);
  endtask : i2c_byte
  task automatic i2c_stop();
    sda_low <= 1'b1;
    tick(4);
    hd[0] <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
    cs_n <= 1'b1;
    tick(4);
  endtask : i2c_stop
endmodule : host_bfm
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench: every strap mode, byte intake, reads, select and init
// Assumes host_bfm as the bus master on the pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hostif_pkg::*;
  localparam logic [5:0] ADDR_HIGH = 6'h15;
  localparam logic [2:0] CODES [6] = '{3'h4, 3'h6, 3'h0, 3'h1, 3'h2, 3'h7};
  logic mclk, srst, init_n, cs_n, dc, e_rd, rw_wr, rd_req, byte_valid, byte_is_data;
  logic init_active, gotd;
  logic [2:0] strap;
  logic [7:0] pins, dout, oe_n, rd_data, byte_data, gotb;
  mode_type proto_mode;
  int miscompares = 0;
  int total_checks = 0;
  int nb = 0;
  int nr = 0;
  host_bfm hb (.mclk(mclk), .two_wire(strap == 3'h2), .oe_n(oe_n), .dout(dout), .cs_n(cs_n),
    .dc(dc), .e_rd(e_rd), .rw_wr(rw_wr), .pins(pins));
  display_host_frontend #(.I2C_ADDR_HIGH(ADDR_HIGH)) DUT (.mclk(mclk), .srst(srst),
    .proto_sel_bit0(strap[0]), .proto_sel_bit1(strap[1]), .proto_sel_bit2(strap[2]),
    .chip_init_n(init_n), .chip_sel_n(cs_n), .dc_sel(dc), .strobe_e_rd(e_rd),
    .strobe_rw_wr(rw_wr), .pin_data_in(pins), .pin_data_out(dout), .pin_data_oe_n(oe_n),
    .rd_data(rd_data), .rd_req(rd_req), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_is_data(byte_is_data), .proto_mode(proto_mode), .init_active(init_active));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (byte_valid === 1'b1) begin
      nb <= nb + 1;
      gotb <= byte_data;
      gotd <= byte_is_data;
    end
    if (rd_req === 1'b1) begin
      nr <= nr + 1;
    end
  end
  function automatic mode_type exp_mode(input logic [2:0] s);
    case (s)
      3'h2: return mode_i2c;
      3'h1: return mode_spi3;
      3'h0: return mode_spi4;
      3'h4: return mode_par68;
      3'h6: return mode_par80;
      default: return mode_none;
    endcase
  endfunction : exp_mode
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic expect_byte(input int n0, input logic [7:0] b, input logic d);
    chk("byte count", 8'(n0 + 1), 8'(nb));
    chk("byte", b, gotb);
    chk("kind", {7'h00, d}, {7'h00, gotd});
  endtask : expect_byte
  task automatic wait_init(input logic v);
    for (int i = 0; i < 40 && init_active !== v; i++) begin
      @(posedge mclk);
    end
    chk("init_active", {7'h00, v}, {7'h00, init_active});
    if (init_active !== v) begin
      tally_and_finish();
    end
  endtask : wait_init
  task automatic restart(input logic [2:0] code);
    @(posedge mclk);
    strap <= code;
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    wait_init(1'b0);
    chk("mode", {5'h00, exp_mode(code)}, {5'h00, proto_mode});
  endtask : restart
  initial begin
    logic [7:0] b, v;
    logic d, ack, m80;
    int n0;
    srst = 1'b1;
    strap = 3'h0;
    init_n = 1'b1;
    rd_data = 8'h00;
    void'($urandom(59));
    foreach (CODES[k]) begin
      restart(CODES[k]);
      m80 = CODES[k][1];
      hb.idle(m80 && CODES[k][2]);
      b = 8'($urandom);
      d = 1'($urandom);
      n0 = nb;
      case (CODES[k])
        3'h4, 3'h6: begin
          for (int j = 0; j < 4; j++) begin
            b = (j == 0) ? 8'hFF : 8'($urandom);
            d = j[0];
            n0 = nb;
            hb.par_write(m80, 1'b0, d, b);
            expect_byte(n0, b, d);
          end
          n0 = nb;
          hb.par_write(m80, 1'b1, 1'b1, 8'hA5);
          chk("deselected", 8'(n0), 8'(nb));
          @(posedge mclk);
          rd_data <= 8'($urandom);
          n0 = nr;
          hb.par_read(m80, v);
          chk("read data", rd_data, v);
          chk("read start", 8'(n0 + 1), 8'(nr));
          chk("bus released", OE_ALL_OFF, oe_n);
        end
        3'h0, 3'h1: begin
          hb.spi(5, 9'h155, 1'b1);
          hb.spi(CODES[k][0] ? 9 : 8, {d, b}, CODES[k][0] ? 1'b0 : d);
          expect_byte(n0, b, d);
        end
        3'h2: begin
          hb.i2c_start(d);
          hb.i2c_byte({ADDR_HIGH, d, 1'b0}, ack);
          chk("address ack", 8'h01, {7'h00, ack});
          hb.i2c_byte(8'h40, ack);
          hb.i2c_byte(b, ack);
          hb.i2c_stop();
          expect_byte(n0, b, 1'b1);
          hb.i2c_start(d);
          hb.i2c_byte({ADDR_HIGH, !d, 1'b0}, ack);
          hb.i2c_stop();
          chk("foreign ack", 8'h00, {7'h00, ack});
        end
        default: begin
          hb.par_write(1'b0, 1'b0, d, b);
          chk("no mode", 8'(n0), 8'(nb));
        end
      endcase
    end
    restart(3'h4);
    hb.par_write(1'b0, 1'b0, 1'b1, 8'h3C);
    @(posedge mclk);
    init_n <= 1'b0;
    wait_init(1'b1);
    @(posedge mclk);
    init_n <= 1'b1;
    wait_init(1'b0);
    chk("byte after init", DATA_RESET, byte_data);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
